// [oag_operand_addr.sv]
// Operand address generator with byte write-back formatting
//
// Functional notes
// - Register operands usable by word or byte instructions.
// - Byte result written to a register has upper eight bits zero.
// - Byte register operations take flags from the 8-bit result.
// - Register, indexed, symbolic, absolute modes for both operands.
// - Each memory operand consumes one extension word after the opcode.
// - Indexed address is base register plus signed extension offset.
// - Base registers stay unchanged by address calculation.
// - Program counter advances past every consumed extension word.
// - Symbolic address is program counter plus extension offset.
// - Symbolic mode increments program counter past offset words.
// - Source mode 00 and destination mode 0 mean register mode.
// - Mode 01/1 is indexed; PC base symbolic, flag register base absolute.
module oag_operand_addr (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Decode request from the fetch/execute unit
    input  wire logic        start_i,
    input  wire logic [15:0] pc_i,
    input  wire logic [1:0]  source_mode_field_i,
    input  wire logic        dst_mode_i,
    input  wire logic [3:0]  src_reg_i,
    input  wire logic [3:0]  dst_reg_i,
    input  wire logic [15:0] src_reg_val_i,
    input  wire logic [15:0] dst_reg_val_i,
    // Program memory read port
    output logic             mem_rd_o,
    output logic [15:0]      mem_addr_o,
    input  wire logic        mem_ack_i,
    input  wire logic [15:0] mem_rdata_i,
    // Address results
    output logic             done_o,
    output logic             mode_err_o,
    output logic             src_mem_o,
    output logic             dst_mem_o,
    output logic [15:0]      src_addr_o,
    output logic [15:0]      dst_addr_o,
    output logic [15:0]      pc_next_o,
    // Register write-back from the ALU
    input  wire logic        wb_req_i,
    input  wire logic        wb_byte_i,
    input  wire logic [3:0]  wb_reg_i,
    input  wire logic [15:0] wb_res_i,
    input  wire logic        wb_c8_i,
    input  wire logic        wb_c16_i,
    output logic             wb_we_o,
    output logic [3:0]       wb_reg_o,
    output logic [15:0]      wb_data_o,
    output logic             flag_n_o,
    output logic             flag_z_o,
    output logic             flag_c_o
);

    // ==========================================================
    // Base selection and address arithmetic

    // PC base is the extension word address, flag register gives zero
    function automatic logic [15:0] sel_base(
        input logic [3:0]  rnum,
        input logic [15:0] rval,
        input logic [15:0] ext_addr
    );
        logic [15:0] b;
        b = rval;
        if (rnum == oag_pkg::OAG_PC_REG_NUM)
            b = ext_addr;
        else if (rnum == oag_pkg::OAG_FLAG_REG_NUM)
            b = oag_pkg::OAG_ZERO_WORD;
        return b;
    endfunction

    // Advance an address by one word
    function automatic logic [15:0] next_word(input logic [15:0] a);
        return 16'(a + oag_pkg::OAG_WORD_STEP);
    endfunction

    // ==========================================================
    // State

    typedef struct packed {
        oag_pkg::oag_state_type st;
        logic [15:0] op_pc;
        logic [15:0] pc;
        logic [3:0]  src_reg;
        logic [3:0]  dst_reg;
        logic [15:0] src_base;
        logic [15:0] dst_base;
        logic        mem_rd;
        logic [15:0] mem_addr;
        logic        done;
        logic        mode_err;
        logic        src_mem;
        logic        dst_mem;
        logic [15:0] src_addr;
        logic [15:0] dst_addr;
        logic        wb_we;
        logic [3:0]  wb_reg;
        logic [15:0] wb_data;
        logic        fn;
        logic        fz;
        logic        fc;
    } oag_regs_type;

    oag_regs_type state_reg;
    oag_regs_type state_next;

    // Next state
    always_comb
    begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.mode_err = 1'b0;
        state_next.wb_we = 1'b0;
        case (state_reg.st)
            oag_pkg::OAG_IDLE:
            begin
                if (start_i)
                begin
                    // Bases only sampled, never written back
                    state_next.op_pc = pc_i;
                    state_next.pc = next_word(pc_i);
                    state_next.src_reg = src_reg_i;
                    state_next.dst_reg = dst_reg_i;
                    state_next.src_base = src_reg_val_i;
                    state_next.dst_base = dst_reg_val_i;
                    state_next.src_addr = oag_pkg::OAG_ZERO_WORD;
                    state_next.dst_addr = oag_pkg::OAG_ZERO_WORD;
                    state_next.src_mem =
                        (source_mode_field_i == oag_pkg::OAG_SRC_MODE_IDX);
                    state_next.dst_mem =
                        (dst_mode_i == oag_pkg::OAG_DST_MODE_IDX);
                    if (source_mode_field_i[1])
                    begin
                        // Indirect modes are not handled here
                        state_next.done = 1'b1;
                        state_next.mode_err = 1'b1;
                        state_next.src_mem = 1'b0;
                        state_next.dst_mem = 1'b0;
                    end
                    else if (source_mode_field_i == oag_pkg::OAG_SRC_MODE_IDX)
                    begin
                        // Source extension word goes first
                        state_next.st = oag_pkg::OAG_SRC_EXT;
                        state_next.mem_rd = 1'b1;
                        state_next.mem_addr = next_word(pc_i);
                    end
                    else if (dst_mode_i == oag_pkg::OAG_DST_MODE_IDX)
                    begin
                        state_next.st = oag_pkg::OAG_DST_EXT;
                        state_next.mem_rd = 1'b1;
                        state_next.mem_addr = next_word(pc_i);
                    end
                    else
                        state_next.done = 1'b1;
                end
            end
            oag_pkg::OAG_SRC_EXT:
            begin
                if (mem_ack_i)
                begin
                    state_next.src_addr = 16'(sel_base(state_reg.src_reg,
                        state_reg.src_base, state_reg.mem_addr)
                        + mem_rdata_i);
                    state_next.pc = next_word(state_reg.mem_addr);
                    if (state_reg.dst_mem)
                    begin
                        state_next.st = oag_pkg::OAG_DST_EXT;
                        state_next.mem_addr = next_word(state_reg.mem_addr);
                    end
                    else
                    begin
                        state_next.st = oag_pkg::OAG_IDLE;
                        state_next.mem_rd = 1'b0;
                        state_next.done = 1'b1;
                    end
                end
            end
            oag_pkg::OAG_DST_EXT:
            begin
                if (mem_ack_i)
                begin
                    state_next.dst_addr = 16'(sel_base(state_reg.dst_reg,
                        state_reg.dst_base, state_reg.mem_addr)
                        + mem_rdata_i);
                    state_next.pc = next_word(state_reg.mem_addr);
                    state_next.st = oag_pkg::OAG_IDLE;
                    state_next.mem_rd = 1'b0;
                    state_next.done = 1'b1;
                end
            end
            default:
            begin
                state_next.st = oag_pkg::OAG_IDLE;
                state_next.mem_rd = 1'b0;
            end
        endcase
        // Write-back formatting, word or byte
        if (wb_req_i)
        begin
            state_next.wb_we = 1'b1;
            state_next.wb_reg = wb_reg_i;
            if (wb_byte_i)
            begin
                state_next.wb_data = {oag_pkg::OAG_ZERO_BYTE,
                                      wb_res_i[7:0]};
                state_next.fn = wb_res_i[7];
                state_next.fz = (wb_res_i[7:0] == oag_pkg::OAG_ZERO_BYTE);
                state_next.fc = wb_c8_i;
            end
            else
            begin
                state_next.wb_data = wb_res_i;
                state_next.fn = wb_res_i[15];
                state_next.fz = (wb_res_i == oag_pkg::OAG_ZERO_WORD);
                state_next.fc = wb_c16_i;
            end
        end
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= '0;
            state_reg.st <= oag_pkg::OAG_IDLE;
            state_reg.wb_reg <= oag_pkg::OAG_RST_REG_NUM;
        end
        else
            state_reg <= state_next;
    end

    // Outputs straight from flops
    assign mem_rd_o   = state_reg.mem_rd;
    assign mem_addr_o = state_reg.mem_addr;
    assign done_o     = state_reg.done;
    assign mode_err_o = state_reg.mode_err;
    assign src_mem_o  = state_reg.src_mem;
    assign dst_mem_o  = state_reg.dst_mem;
    assign src_addr_o = state_reg.src_addr;
    assign dst_addr_o = state_reg.dst_addr;
    assign pc_next_o  = state_reg.pc;
    assign wb_we_o    = state_reg.wb_we;
    assign wb_reg_o   = state_reg.wb_reg;
    assign wb_data_o  = state_reg.wb_data;
    assign flag_n_o   = state_reg.fn;
    assign flag_z_o   = state_reg.fz;
    assign flag_c_o   = state_reg.fc;

    // ==========================================================
    // Assertions

    wire idle_w = (state_reg.st == oag_pkg::OAG_IDLE);

    // All checks run on the CPU clock, quiet during reset
    default clocking chk_cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Start of a two-operand memory instruction
    sequence s_start_both;
        start_i && idle_w && source_mode_field_i == oag_pkg::OAG_SRC_MODE_IDX
            && dst_mode_i == oag_pkg::OAG_DST_MODE_IDX;
    endsequence

    // Source extension word taken
    sequence s_src_taken;
        state_reg.st == oag_pkg::OAG_SRC_EXT && mem_ack_i;
    endsequence

    byte_clear_a: assert property (
        wb_req_i && wb_byte_i |=> wb_we_o
            && wb_data_o == {8'h00, $past(wb_res_i[7:0])})
        else $error("byte write did not clear upper byte");

    word_pass_a: assert property (
        wb_req_i && !wb_byte_i |=> wb_we_o && wb_data_o == $past(wb_res_i))
        else $error("word write altered result");

    byte_flags_a: assert property (
        wb_req_i && wb_byte_i |=> flag_n_o == $past(wb_res_i[7])
            && flag_z_o == ($past(wb_res_i[7:0]) == 8'h00))
        else $error("byte flags not from low byte");

    src_first_a: assert property (
        s_start_both |=> mem_rd_o && mem_addr_o == 16'($past(pc_i) + 16'h0002)
            && state_reg.st == oag_pkg::OAG_SRC_EXT)
        else $error("source extension word not fetched first");

    dst_second_a: assert property (
        s_src_taken ##0 state_reg.dst_mem |=> mem_rd_o
            && mem_addr_o == 16'(state_reg.op_pc + 16'h0004))
        else $error("destination extension word misplaced");

    ext_count_a: assert property (
        done_o && !mode_err_o |-> pc_next_o == 16'(state_reg.op_pc + 16'h0002
            + (src_mem_o ? 16'h0002 : 16'h0000)
            + (dst_mem_o ? 16'h0002 : 16'h0000)))
        else $error("program counter not past extension words");

    idx_addr_a: assert property (
        s_src_taken ##0 (state_reg.src_reg != 4'h0 && state_reg.src_reg != 4'h2)
            |=> src_addr_o == 16'($past(state_reg.src_base)
                + $past(mem_rdata_i)))
        else $error("indexed address wrong");

    sym_base_a: assert property (
        s_src_taken ##0 state_reg.src_reg == 4'h0 |=> src_addr_o
            == 16'($past(mem_addr_o) + $past(mem_rdata_i)))
        else $error("symbolic address wrong");

    abs_zero_a: assert property (
        s_src_taken ##0 state_reg.src_reg == 4'h2
            |=> src_addr_o == $past(mem_rdata_i))
        else $error("absolute address not zero based");

    reg_mode_a: assert property (
        start_i && idle_w && source_mode_field_i == 2'h0 && !dst_mode_i
            |=> done_o && !src_mem_o && !dst_mem_o && !mem_rd_o)
        else $error("register mode fetched memory");

endmodule

// [oag_pkg.sv]
// Constants and types shared by the operand address generator
package oag_pkg;

    // ==========================================================
    // Register numbers with special meaning as a base
    localparam logic [3:0]  OAG_PC_REG_NUM   = 4'h0;
    localparam logic [3:0]  OAG_FLAG_REG_NUM = 4'h2;

    // ==========================================================
    // Mode field encodings
    localparam logic [1:0]  OAG_SRC_MODE_REG = 2'h0;
    localparam logic [1:0]  OAG_SRC_MODE_IDX = 2'h1;
    localparam logic        OAG_DST_MODE_REG = 1'b0;
    localparam logic        OAG_DST_MODE_IDX = 1'b1;

    // ==========================================================
    // Address arithmetic and reset values
    localparam logic [15:0] OAG_WORD_STEP    = 16'h0002;
    localparam logic [15:0] OAG_ZERO_WORD    = 16'h0000;
    localparam logic [7:0]  OAG_ZERO_BYTE    = 8'h00;
    localparam logic [3:0]  OAG_RST_REG_NUM  = 4'h0;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        OAG_IDLE,
        OAG_SRC_EXT,
        OAG_DST_EXT
    } oag_state_type;

endpackage

// [oag_mem_model.sv]
// Behavioural program memory that answers extension word reads
module oag_mem_model (
    input  wire logic        mclk_i,
    input  wire logic        mem_rd_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [3:0]  dly_i,
    output logic             mem_ack_o,
    output logic [15:0]      mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] img [logic [15:0]];
    logic [3:0]  wait_cnt = 4'h0;
    logic [15:0] last_q   = 16'h0000;

    // ==========================================================
    // Program image, symbolic words hold target minus word address
    task automatic load(input logic [15:0] a, input logic [15:0] d);
        img[a] = d;
    endtask

    // Answer after dly_i wait cycles, idle data is last word inverted
    assign mem_ack_o = mem_rd_i && (wait_cnt == dly_i);
    always_comb
    begin
        mem_rdata_o = ~last_q;
        if (mem_ack_o && img.exists(mem_addr_i))
            mem_rdata_o = img[mem_addr_i];
    end

    // Wait counter and last delivered word
    always_ff @(posedge mclk_i)
    begin
        if (mem_ack_o)
        begin
            wait_cnt <= 4'h0;
            last_q   <= mem_rdata_o;
        end
        else if (mem_rd_i)
            wait_cnt <= wait_cnt + 4'h1;
    end
endmodule

// [tb_top.sv]
// Self-checking bench for the operand address generator
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    logic        start = 1'b0;
    logic [15:0] pc = 16'h0000;
    logic [1:0]  sm = 2'h0;
    logic        dm = 1'b0;
    logic [3:0]  sr = 4'h0;
    logic [3:0]  dr = 4'h0;
    logic [15:0] sv = 16'h0000;
    logic [15:0] dv = 16'h0000;
    logic [3:0]  dly = 4'h0;
    logic        wb_req = 1'b0;
    logic        wb_byte = 1'b0;
    logic [3:0]  wb_reg = 4'h0;
    logic [15:0] wb_res = 16'h0000;
    logic        c8 = 1'b0;
    logic        c16 = 1'b0;
    logic        mem_rd, mem_ack, done, merr, s_mem, d_mem;
    logic        wb_we, fn, fz, fc;
    logic [15:0] mem_addr, mem_rdata, s_addr, d_addr, pc_nx, wb_data;
    logic [3:0]  wb_reg_q;
    int          error_cnt = 0;
    int          num_checks = 0;
    logic [15:0] fetch_q [$];

    // ==========================================================
    // Clock, design and memory
    always #50 mclk = ~mclk;

    oag_operand_addr i_dut (
        .mclk_i(mclk), .sys_rst_i(rst), .start_i(start), .pc_i(pc),
        .source_mode_field_i(sm), .dst_mode_i(dm), .src_reg_i(sr),
        .dst_reg_i(dr), .src_reg_val_i(sv), .dst_reg_val_i(dv),
        .mem_rd_o(mem_rd), .mem_addr_o(mem_addr), .mem_ack_i(mem_ack),
        .mem_rdata_i(mem_rdata), .done_o(done), .mode_err_o(merr),
        .src_mem_o(s_mem), .dst_mem_o(d_mem), .src_addr_o(s_addr),
        .dst_addr_o(d_addr), .pc_next_o(pc_nx), .wb_req_i(wb_req),
        .wb_byte_i(wb_byte), .wb_reg_i(wb_reg), .wb_res_i(wb_res),
        .wb_c8_i(c8), .wb_c16_i(c16), .wb_we_o(wb_we),
        .wb_reg_o(wb_reg_q), .wb_data_o(wb_data), .flag_n_o(fn),
        .flag_z_o(fz), .flag_c_o(fc));

    oag_mem_model i_mem (
        .mclk_i(mclk), .mem_rd_i(mem_rd), .mem_addr_i(mem_addr),
        .dly_i(dly), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));

    // Log of every accepted extension word address
    always @(posedge mclk)
        if (mem_rd === 1'b1 && mem_ack === 1'b1)
            fetch_q.push_back(mem_addr);

    // ==========================================================
    // Shared helpers
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    function automatic logic [15:0] base(input logic [3:0] r,
        input logic [15:0] v, input logic [15:0] w);
        if (r == oag_pkg::OAG_PC_REG_NUM)
            return w;
        return (r == oag_pkg::OAG_FLAG_REG_NUM) ? 16'h0000 : v;
    endfunction

    // One decode: loads ext words, runs it, judges every result
    task automatic dec(input logic [15:0] p, input logic [1:0] m_s,
        input logic m_d, input logic [3:0] r_s, input logic [3:0] r_d,
        input logic [15:0] v_s, input logic [15:0] v_d,
        input logic [15:0] x, input logic [15:0] y, input int lat);
        logic [15:0] ea_s, ea_d, nx;
        logic [15:0] exp_q [$];
        logic        bad;
        int          n;
        bad = m_s[1];
        nx = p + 16'h0002;
        ea_s = 16'h0000;
        ea_d = 16'h0000;
        if (!bad && m_s == 2'h1)
        begin
            i_mem.load(nx, x);
            ea_s = base(r_s, v_s, nx) + x;
            exp_q.push_back(nx);
            nx = nx + 16'h0002;
        end
        if (!bad && m_d)
        begin
            i_mem.load(nx, y);
            ea_d = base(r_d, v_d, nx) + y;
            exp_q.push_back(nx);
            nx = nx + 16'h0002;
        end
        fetch_q.delete();
        pc = p;
        sm = m_s;
        dm = m_d;
        sr = r_s;
        dr = r_d;
        sv = v_s;
        dv = v_d;
        start = 1'b1;
        @(posedge mclk);
        #1 start = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 60)
        begin
            @(posedge mclk);
            #1 n++;
        end
        chk(done === 1'b1 && (lat == 0 || n == lat), "done timing");
        chk(merr === bad, "mode error flag");
        chk(s_mem === (!bad && m_s == 2'h1), "source in memory");
        chk(d_mem === (!bad && m_d), "destination in memory");
        chk(s_addr === ea_s, "source address");
        chk(d_addr === ea_d, "destination address");
        chk(bad || pc_nx === nx, "next instruction address");
        chk(fetch_q == exp_q, "extension fetch order");
        chk(wb_we === 1'b0, "register written during decode");
        $display("decode at %h mode %h/%h finished", p, m_s, m_d);
    endtask

    // One write-back request, judged in the following cycle
    task automatic wb(input logic b, input logic [15:0] r,
        input logic k8, input logic k16, input logic [3:0] rg);
        logic [15:0] e;
        e = b ? {8'h00, r[7:0]} : r;
        wb_req = 1'b1;
        wb_byte = b;
        wb_res = r;
        wb_reg = rg;
        c8 = k8;
        c16 = k16;
        @(posedge mclk);
        #1 chk(wb_we === 1'b1 && wb_reg_q === rg, "write strobe");
        chk(wb_data === e, "write-back data");
        chk(fn === (b ? r[7] : r[15]), "negative flag");
        chk(fz === (e == 16'h0000), "zero flag");
        chk(fc === (b ? k8 : k16), "carry flag");
    endtask

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        dec(16'hff12, 2'h0, 1'b0, 4'h4, 4'h5, 16'ha023, 16'hfa15,
            16'h0000, 16'h0000, 1);
        dec(16'hff12, 2'h1, 1'b1, 4'h5, 4'h6, 16'h1080, 16'h108c,
            16'h0002, 16'h0006, 3);
        dly = 4'h3;
        dec(16'hff12, 2'h1, 1'b1, 4'h0, 4'h0, 16'h1234, 16'h5678,
            16'hf102, 16'h11fe, 0);
        dly = 4'h0;
        dec(16'hff12, 2'h1, 1'b1, 4'h2, 4'h2, 16'h4321, 16'h8765,
            16'hf016, 16'h1114, 3);
        dec(16'h0200, 2'h0, 1'b1, 4'h7, 4'h0, 16'h1111, 16'h2222,
            16'h0000, 16'hfff0, 2);
        dec(16'h0300, 2'h1, 1'b0, 4'h8, 4'h9, 16'h7ffe, 16'h0000,
            16'h8004, 16'h0000, 2);
        dec(16'h0400, 2'h2, 1'b0, 4'h8, 4'h9, 16'h0000, 16'h0000,
            16'h0000, 16'h0000, 1);
        wb(1'b1, 16'h1280, 1'b1, 1'b0, 4'h4);
        wb(1'b1, 16'hff00, 1'b0, 1'b1, 4'h5);
        wb(1'b0, 16'h8000, 1'b0, 1'b1, 4'h6);
        wb(1'b0, 16'h0100, 1'b1, 1'b0, 4'h7);
        wb_req = 1'b0;
        @(posedge mclk);
        #1 chk(wb_we === 1'b0, "write strobe not a pulse");
        $display("write-back test finished");
        end_sim();
    end

    // Watchdog
    initial
    begin
        #(5000 * 100);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule
